// *** rtl/jmap_tap.sv ***
// test access port with memory access data registers
// assumes tck/tms/tdi come from an asynchronous host and are sampled here
`timescale 1ns/1ps
`include "jmap_defs.svh"

module jmap_tap (
	input  wire logic                   I_REF_CLK,
	input  wire logic                   I_NRST,
	input  wire logic                   I_TCK,
	input  wire logic                   I_TMS,
	input  wire logic                   I_TDI,
	input  wire logic [31:0]            I_USER_CODE,
	input  wire logic [7:0]             I_MEM_RDATA,
	output logic                        O_TDO,
	output logic                        O_TDO_OE,
	output jmap_pkg::jmap_mem_req_t     O_MEM_REQ,
	output jmap_pkg::jmap_ctl_t         O_CTL
);
	import jmap_pkg::*;

	// ***************************************************
	// pin sampling and edge detection
	// ***************************************************
	logic [2:0]  tck_sync_ff;
	logic [1:0]  tms_sync_ff;
	logic [1:0]  tdi_sync_ff;
	logic        tck_rise;
	logic        tck_fall;
	logic        tms;
	logic        tdi;

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			tck_sync_ff <= 3'h0;
			tms_sync_ff <= 2'h3;
			tdi_sync_ff <= 2'h0;
		end
		else
		begin
			tck_sync_ff <= {tck_sync_ff[1:0], I_TCK};
			tms_sync_ff <= {tms_sync_ff[0], I_TMS};
			tdi_sync_ff <= {tdi_sync_ff[0], I_TDI};
		end
	end

	assign tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
	assign tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
	assign tms      = tms_sync_ff[1];
	assign tdi      = tdi_sync_ff[1];

	// ***************************************************
	// controller
	// ***************************************************
	jmap_state_t state_ff;
	jmap_state_t nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			JMAP_RESET:  nxt_state = tms ? JMAP_RESET  : JMAP_IDLE;
			JMAP_IDLE:   nxt_state = tms ? JMAP_SEL_DR : JMAP_IDLE;
			JMAP_SEL_DR: nxt_state = tms ? JMAP_SEL_IR : JMAP_CAP_DR;
			JMAP_CAP_DR: nxt_state = tms ? JMAP_EX1_DR : JMAP_SH_DR;
			JMAP_SH_DR:  nxt_state = tms ? JMAP_EX1_DR : JMAP_SH_DR;
			JMAP_EX1_DR: nxt_state = tms ? JMAP_UPD_DR : JMAP_PAU_DR;
			JMAP_PAU_DR: nxt_state = tms ? JMAP_EX2_DR : JMAP_PAU_DR;
			JMAP_EX2_DR: nxt_state = tms ? JMAP_UPD_DR : JMAP_SH_DR;
			JMAP_UPD_DR: nxt_state = tms ? JMAP_SEL_DR : JMAP_IDLE;
			JMAP_SEL_IR: nxt_state = tms ? JMAP_RESET  : JMAP_CAP_IR;
			JMAP_CAP_IR: nxt_state = tms ? JMAP_EX1_IR : JMAP_SH_IR;
			JMAP_SH_IR:  nxt_state = tms ? JMAP_EX1_IR : JMAP_SH_IR;
			JMAP_EX1_IR: nxt_state = tms ? JMAP_UPD_IR : JMAP_PAU_IR;
			JMAP_PAU_IR: nxt_state = tms ? JMAP_EX2_IR : JMAP_PAU_IR;
			JMAP_EX2_IR: nxt_state = tms ? JMAP_UPD_IR : JMAP_SH_IR;
			JMAP_UPD_IR: nxt_state = tms ? JMAP_SEL_DR : JMAP_IDLE;
			default:     nxt_state = JMAP_RESET;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			state_ff <= JMAP_RESET;
		else if (tck_rise)
			state_ff <= nxt_state;
	end

	// ***************************************************
	// instruction register
	// ***************************************************
	logic [`JMAP_IR_W-1:0] ir_shift_ff;
	logic [`JMAP_IR_W-1:0] ir_ff;

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			ir_shift_ff <= `JMAP_IR_CAPTURE;
		else if (tck_rise && state_ff == JMAP_CAP_IR)
			ir_shift_ff <= `JMAP_IR_CAPTURE;
		else if (tck_rise && state_ff == JMAP_SH_IR)
			ir_shift_ff <= {tdi, ir_shift_ff[`JMAP_IR_W-1:1]};
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			ir_ff <= `JMAP_OP_IDCODE;
		else if (state_ff == JMAP_RESET)
			ir_ff <= `JMAP_OP_IDCODE;
		else if (tck_fall && state_ff == JMAP_UPD_IR)
			ir_ff <= ir_shift_ff;
	end

	// ***************************************************
	// decoding
	// ***************************************************
	typedef enum logic [2:0] {
		JMAP_SEL_BYP  = 3'h0,
		JMAP_SEL_ID   = 3'h1,
		JMAP_SEL_USER = 3'h2,
		JMAP_SEL_ADDR = 3'h3,
		JMAP_SEL_RD   = 3'h4,
		JMAP_SEL_WR   = 3'h5
	} jmap_dr_t;

	function automatic jmap_dr_t dr_select(input logic [`JMAP_IR_W-1:0] op);
		unique case (op)
			`JMAP_OP_IDCODE:     dr_select = JMAP_SEL_ID;
			`JMAP_OP_USERCODE:   dr_select = JMAP_SEL_USER;
			`JMAP_OP_LOAD_ADDR:  dr_select = JMAP_SEL_ADDR;
			`JMAP_OP_READ_DATA:  dr_select = JMAP_SEL_RD;
			`JMAP_OP_WRITE_DATA: dr_select = JMAP_SEL_WR;
			default:             dr_select = JMAP_SEL_BYP;
		endcase
	endfunction : dr_select

	jmap_dr_t sel;
	assign sel = dr_select(ir_ff);

	// ***************************************************
	// data registers
	// ***************************************************
	logic [`JMAP_WORD_W-1:0] dr_ff;
	logic [`JMAP_WORD_W-1:0] id_code;
	logic [`JMAP_WORD_W-1:0] cap_val;
	logic [`JMAP_WORD_W-1:0] shifted;
	logic                    dr_lsb;

	assign id_code = {`JMAP_ID_VERSION, `JMAP_ID_PART, `JMAP_ID_MAKER,
		`JMAP_ID_FIXED};

	always_comb
	begin
		cap_val = 32'h0;
		shifted = dr_ff;
		unique case (sel)
			JMAP_SEL_BYP:  cap_val = 32'h0;
			JMAP_SEL_ID:   cap_val = id_code;
			JMAP_SEL_USER: cap_val = I_USER_CODE;
			JMAP_SEL_RD:   cap_val = {24'h0, I_MEM_RDATA};
			JMAP_SEL_ADDR: cap_val = {24'h0, O_MEM_REQ.addr};
			JMAP_SEL_WR:   cap_val = {24'h0, O_MEM_REQ.wdata};
		endcase
		unique case (sel)
			JMAP_SEL_BYP:  shifted = {31'h0, tdi};
			JMAP_SEL_ID, JMAP_SEL_USER:
				shifted = {tdi, dr_ff[31:1]};
			JMAP_SEL_ADDR, JMAP_SEL_RD, JMAP_SEL_WR:
				shifted = {24'h0, tdi, dr_ff[7:1]};
		endcase
	end

	assign dr_lsb = dr_ff[0];

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			dr_ff <= 32'h0;
		else if (tck_rise && state_ff == JMAP_CAP_DR)
			dr_ff <= cap_val;
		else if (tck_rise && state_ff == JMAP_SH_DR)
			dr_ff <= shifted;
	end

	// ***************************************************
	// update latches and memory requests
	// ***************************************************
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			O_MEM_REQ <= '0;
		else
		begin
			O_MEM_REQ.rd <= 1'b0;
			O_MEM_REQ.wr <= 1'b0;
			if (tck_fall && state_ff == JMAP_UPD_DR)
			begin
				unique case (sel)
					JMAP_SEL_ADDR: O_MEM_REQ.addr <= dr_ff[7:0];
					JMAP_SEL_RD:   O_MEM_REQ.rd <= 1'b1;
					JMAP_SEL_WR:
					begin
						O_MEM_REQ.wdata <= dr_ff[7:0];
						O_MEM_REQ.wr    <= 1'b1;
					end
					default: O_MEM_REQ.rd <= 1'b0;
				endcase
			end
		end
	end

	// ***************************************************
	// device controls
	// ***************************************************
	logic upd_ir_fall;
	logic hit_reboot;
	logic hit_save;
	logic hit_ext_on;
	logic hit_ext_off;
	logic hit_nvm_on;
	logic hit_nvm_off;

	// shifted code equals the given operation
	function automatic logic op_is(input logic [`JMAP_IR_W-1:0] code,
		input logic [`JMAP_IR_W-1:0] op);
		op_is = code == op;
	endfunction : op_is

	assign upd_ir_fall = tck_fall && state_ff == JMAP_UPD_IR;
	assign hit_reboot  = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_REBOOT);
	assign hit_save    = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_SAVE);
	assign hit_ext_on  = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_EXT_ENTER);
	assign hit_ext_off = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_EXT_LEAVE);
	assign hit_nvm_on  = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_NVM_ENTER);
	assign hit_nvm_off = upd_ir_fall &&
		op_is(ir_shift_ff, `JMAP_OP_NVM_LEAVE);

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			O_CTL <= '0;
		else
		begin
			O_CTL.reboot <= hit_reboot;
			O_CTL.save   <= hit_save;
			if (hit_ext_on)
				O_CTL.ext_page <= 1'b1;
			else if (hit_ext_off)
				O_CTL.ext_page <= 1'b0;
			if (hit_nvm_on)
				O_CTL.nvm_page <= 1'b1;
			else if (hit_nvm_off)
				O_CTL.nvm_page <= 1'b0;
		end
	end

	// ***************************************************
	// serial output
	// ***************************************************
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			O_TDO    <= 1'b0;
			O_TDO_OE <= 1'b0;
		end
		else if (tck_fall)
		begin
			O_TDO_OE <= state_ff == JMAP_SH_DR ||
				state_ff == JMAP_SH_IR;
			O_TDO    <= (state_ff == JMAP_SH_IR) ? ir_shift_ff[0] :
				dr_lsb;
		end
	end

endmodule : jmap_tap

// *** rtl/jmap_defs.svh ***
// constants for the test access port: instruction codes, capture values,
// register widths and identity fields
// assumes inclusion by bare name from the package and the design file
`ifndef JMAP_DEFS_SVH
`define JMAP_DEFS_SVH

`define JMAP_IR_W           5
`define JMAP_IR_CAPTURE     5'h01
`define JMAP_OP_BYPASS      5'h1f
`define JMAP_OP_IDCODE      5'h00
`define JMAP_OP_USERCODE    5'h03
`define JMAP_OP_LOAD_ADDR   5'h04
`define JMAP_OP_READ_DATA   5'h05
`define JMAP_OP_WRITE_DATA  5'h06
`define JMAP_OP_REBOOT      5'h07
`define JMAP_OP_SAVE        5'h08
`define JMAP_OP_EXT_ENTER   5'h09
`define JMAP_OP_EXT_LEAVE   5'h0a
`define JMAP_OP_NVM_ENTER   5'h0b
`define JMAP_OP_NVM_LEAVE   5'h0c
`define JMAP_WORD_W         32
`define JMAP_BYTE_W         8
// identity fields: values are arbitrary
`define JMAP_ID_VERSION     4'h3
`define JMAP_ID_PART        16'h5a5a
`define JMAP_ID_MAKER       11'h2a5
`define JMAP_ID_FIXED       1'h1

`endif

// *** rtl/jmap_pkg.sv ***
// types shared by the test access port
// assumes the defines header is on the include path
`include "jmap_defs.svh"

package jmap_pkg;

	typedef enum logic [15:0] {
		JMAP_RESET   = 16'h0001,
		JMAP_IDLE    = 16'h0002,
		JMAP_SEL_DR  = 16'h0004,
		JMAP_CAP_DR  = 16'h0008,
		JMAP_SH_DR   = 16'h0010,
		JMAP_EX1_DR  = 16'h0020,
		JMAP_PAU_DR  = 16'h0040,
		JMAP_EX2_DR  = 16'h0080,
		JMAP_UPD_DR  = 16'h0100,
		JMAP_SEL_IR  = 16'h0200,
		JMAP_CAP_IR  = 16'h0400,
		JMAP_SH_IR   = 16'h0800,
		JMAP_EX1_IR  = 16'h1000,
		JMAP_PAU_IR  = 16'h2000,
		JMAP_EX2_IR  = 16'h4000,
		JMAP_UPD_IR  = 16'h8000
	} jmap_state_t;

	// memory-side request toward the device's memory
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} jmap_mem_req_t;

	// device-level controls from instructions
	typedef struct packed {
		logic reboot;
		logic save;
		logic ext_page;
		logic nvm_page;
	} jmap_ctl_t;

endpackage : jmap_pkg

// *** verification/jmap_tap_chk.sv ***
// assertions on the test access port pins
// assumes binding to jmap_tap; tck and tms arrive unsynchronised
`timescale 1ns/1ps
module jmap_tap_chk (
	input  wire logic                    I_REF_CLK,
	input  wire logic                    I_NRST,
	input  wire logic                    I_TCK,
	input  wire logic                    I_TMS,
	input  wire logic                    I_TDI,
	input  wire logic [31:0]             I_USER_CODE,
	input  wire logic [7:0]              I_MEM_RDATA,
	input  wire logic                    O_TDO,
	input  wire logic                    O_TDO_OE,
	input  wire jmap_pkg::jmap_mem_req_t O_MEM_REQ,
	input  wire jmap_pkg::jmap_ctl_t     O_CTL
);
	import jmap_pkg::*;
	// ****
	// assertions
	// ****
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	logic [2:0] hi_ff;
	// counts tck rises in a row with tms high
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			hi_ff <= 3'h0;
		else if ($rose(I_TCK))
			hi_ff <= I_TMS ? hi_ff + {2'h0, hi_ff != 3'h7} : 3'h0;
	end
	a_rd_single: assert property (O_MEM_REQ.rd |=> !O_MEM_REQ.rd)
		else $error("read pulse too long");
	a_wr_single: assert property (O_MEM_REQ.wr |=> !O_MEM_REQ.wr)
		else $error("write pulse too long");
	a_rd_wr_apart: assert property (!(O_MEM_REQ.rd && O_MEM_REQ.wr))
		else $error("read and write together");
	a_reboot_pulse: assert property (O_CTL.reboot |=> !O_CTL.reboot)
		else $error("reboot pulse too long");
	a_save_pulse: assert property (O_CTL.save |=> !O_CTL.save)
		else $error("save pulse too long");
	a_tdo_on_fall: assert property ($changed(O_TDO) |-> !I_TCK)
		else $error("tdo moved while tck high");
	a_oe_on_fall: assert property ($changed(O_TDO_OE) |-> !I_TCK)
		else $error("tdo enable moved while tck high");
	a_dr_latch_fall: assert property ($changed(O_MEM_REQ) |-> !I_TCK)
		else $error("memory request moved while tck high");
	a_ir_latch_fall: assert property ($changed(O_CTL) |-> !I_TCK)
		else $error("controls moved while tck high");
	a_shift_exit: assert property (hi_ff >= 3'h2 |-> !O_TDO_OE)
		else $error("tdo driven after leaving shift");
endmodule : jmap_tap_chk

bind jmap_tap jmap_tap_chk u_chk (
	.I_REF_CLK, .I_NRST, .I_TCK, .I_TMS, .I_TDI, .I_USER_CODE,
	.I_MEM_RDATA, .O_TDO, .O_TDO_OE, .O_MEM_REQ, .O_CTL
);

// *** verification/jmap_host.sv ***
// test host model: drives tck, tms, tdi and samples tdo
// assumes the device reference clock; tck stands low between calls
`timescale 1ns/1ps
module jmap_host (
	input  wire logic i_clk,
	input  wire logic i_tdo,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi
);
	// ****
	// host
	// ****
	// the host alone reaches memory while it runs
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// one 80 ns tck period; tdi released to the inverse after it
	task automatic step(input logic tms, input logic tdi,
		output logic tdo);
		@(posedge i_clk);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (5) @(posedge i_clk);
		tdo = i_tdo;
		o_tck <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_tck <= 1'b0;
		o_tdi <= ~tdi;
	endtask : step
endmodule : jmap_host

// *** verification/jmap_tap_bench.sv ***
// self-checking bench for the test access port
// assumes host model and checker are compiled beforehand
`timescale 1ns/1ps
`include "jmap_defs.svh"
module jmap_tap_bench;
	import jmap_pkg::*;
	// ****
	// set-up
	// ****
	localparam logic [31:0] id_code = {`JMAP_ID_VERSION, `JMAP_ID_PART,
		`JMAP_ID_MAKER, `JMAP_ID_FIXED};
	logic          ref_clk = 1'b0;
	logic          nrst;
	logic [31:0]   user_code;
	logic [7:0]    mem_rdata;
	logic          tck, tms, tdi, tdo;
	logic          tdo_oe;
	jmap_mem_req_t mem_req;
	jmap_ctl_t     ctl;
	logic [31:0]   v;
	int            mismatches = 0;
	int            n_checks = 0;
	int            n_oe = 0;
	int            n_rd = 0, n_wr = 0, n_reb = 0, n_sav = 0;
	always #4 ref_clk = ~ref_clk;
	jmap_tap DUT (.I_REF_CLK(ref_clk), .I_NRST(nrst), .I_TCK(tck),
		.I_TMS(tms), .I_TDI(tdi), .I_USER_CODE(user_code),
		.I_MEM_RDATA(mem_rdata), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
		.O_MEM_REQ(mem_req), .O_CTL(ctl));
	jmap_host h (.i_clk(ref_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms),
		.o_tdi(tdi));
	always @(posedge ref_clk)
	begin
		n_rd <= n_rd + int'(mem_req.rd === 1'b1);
		n_wr <= n_wr + int'(mem_req.wr === 1'b1);
		n_reb <= n_reb + int'(ctl.reboot === 1'b1);
		n_sav <= n_sav + int'(ctl.save === 1'b1);
		n_oe <= n_oe + int'(tdo_oe === 1'b1);
	end
	// ****
	// tasks
	// ****
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	// idle to shift, n bits lsb first, optional pause after the first pz bits
	task automatic scan(input logic ir, input logic [31:0] din,
		input int n, input int pz, output logic [31:0] dout);
		logic t;
		dout = '0;
		h.step(1'b1, 1'b0, t);
		if (ir)
			h.step(1'b1, 1'b0, t);
		h.step(1'b0, 1'b0, t);
		h.step(1'b0, 1'b0, t);
		for (int i = 0; i < n; i++)
		begin
			h.step(i == n - 1 || i == pz - 1, din[i], dout[i]);
			if (i == pz - 1)
			begin
				h.step(1'b0, 1'b0, t);
				h.step(1'b0, 1'b0, t);
				h.step(1'b1, 1'b0, t);
				h.step(1'b0, 1'b0, t);
			end
		end
		h.step(1'b1, 1'b0, t);
		h.step(1'b0, 1'b0, t);
	endtask : scan
	task automatic ir(input logic [4:0] c);
		logic [31:0] d;
		scan(1'b1, {27'h0, c}, 5, 0, d);
	endtask : ir
	task automatic dr(input logic [31:0] d, input int n);
		scan(1'b0, d, n, 0, v);
	endtask : dr
	task automatic report_and_stop();
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	// ****
	// scenarios
	// ****
	task automatic t_tms_reset();
		logic t;
		int   o0;
		repeat (5) h.step(1'b1, 1'b0, t);
		h.step(1'b0, 1'b0, t);
		o0 = n_oe;
		scan(1'b0, 32'h0, 32, 16, v);
		chk("idcode", id_code, v);
		// ten clocks per bit, enable off while paused
		chk("oe cycles", 32'h140, n_oe - o0);
		chk("id lsb", 32'h1, {31'h0, v[0]});
	endtask : t_tms_reset
	task automatic t_ir_bypass();
		scan(1'b1, 32'h1f, 5, 2, v);
		chk("ir capture", 32'h01, v);
		dr(32'hb5, 9);
		chk("bypass", 32'hb5, {24'h0, v[8:1]});
		ir(5'h1e);
		dr(32'h4c, 9);
		chk("unlisted", 32'h4c, {24'h0, v[8:1]});
		ir(5'h03);
		dr(32'h0, 32);
		chk("user code", user_code, v);
	endtask : t_ir_bypass
	task automatic t_mem();
		ir(5'h04);
		dr(32'h5c, 8);
		chk("addr", 32'h5c, {24'h0, mem_req.addr});
		ir(5'h06);
		dr(32'ha7, 8);
		chk("wdata", 32'ha7, {24'h0, mem_req.wdata});
		chk("writes", 32'h1, n_wr);
		ir(5'h05);
		dr(32'h0, 8);
		chk("rdata", 32'h3c, v);
		chk("reads", 32'h1, n_rd);
	endtask : t_mem
	task automatic t_ctl();
		ir(5'h07);
		chk("reboot", 32'h1, n_reb);
		ir(5'h08);
		chk("save", 32'h1, n_sav);
		ir(5'h09);
		ir(5'h0b);
		chk("pages on", 32'h3, {30'h0, ctl.ext_page, ctl.nvm_page});
		ir(5'h04);
		dr(32'h21, 8);
		ir(5'h05);
		dr(32'h0, 8);
		ir(5'h04);
		dr(32'h21, 8);
		ir(5'h0a);
		chk("ext off", 32'h1, {30'h0, ctl.ext_page, ctl.nvm_page});
		ir(5'h0c);
		chk("nvm off", 32'h0, {30'h0, ctl.ext_page, ctl.nvm_page});
		chk("reboots", 32'h1, n_reb);
		chk("reads", 32'h2, n_rd);
	endtask : t_ctl
	// ****
	// run
	// ****
	initial
	begin
		nrst <= 1'b0;
		user_code <= 32'hc3a5_0f96;
		mem_rdata <= 8'h3c;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_tms_reset();
		t_ir_bypass();
		t_mem();
		t_ctl();
		scan(1'b1, 32'h7, 3, 0, v);
		t_tms_reset();
		report_and_stop();
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		report_and_stop();
	end
endmodule : jmap_tap_bench
